//--- hdl/lcdc_pkg.sv
// lcdc_pkg: opcode patterns, field positions, reset values and blink divisors
// for the lcd command decoder; shared by all design files.
package lcdc_pkg;

    // ------------------------------------------------------------
    // command byte layout
    // ------------------------------------------------------------
    localparam int CONT_BIT = 7;
    localparam logic [1:0] OP_MODE_SET  = 2'h2;   // bits 6:5
    localparam logic [1:0] OP_LOAD_PTR  = 2'h0;   // bits 6:5
    localparam logic [3:0] OP_DEV_SEL   = 4'hc;   // bits 6:3
    localparam logic [4:0] OP_BANK_SEL  = 5'h1e;  // bits 6:2
    localparam logic [3:0] OP_BLINK_SEL = 4'he;   // bits 6:3
    localparam int ENABLE_BIT = 3;
    localparam int BIAS_BIT   = 2;
    localparam int IBANK_BIT  = 1;
    localparam int OBANK_BIT  = 0;
    localparam int ALTB_BIT   = 2;

    // ------------------------------------------------------------
    // drive modes (bits 1:0 of mode-set)
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LCDC_MUX4   = 2'h0,
        LCDC_STATIC = 2'h1,
        LCDC_MUX2   = 2'h2,
        LCDC_MUX3   = 2'h3
    } lcdc_mode_t;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0] RST_MODE   = 2'h0;
    localparam logic       RST_ENABLE = 1'b0;
    localparam logic       RST_BIAS   = 1'b0;
    localparam logic [4:0] RST_PTR    = 5'h00;
    localparam logic [2:0] RST_SUBADR = 3'h0;
    localparam logic [1:0] RST_BLINK  = 2'h0;

    // ------------------------------------------------------------
    // blink toggle divisors of the display clock
    // ------------------------------------------------------------
    localparam int BLINK_DIV1 = 768;
    localparam int BLINK_DIV2 = 1536;
    localparam int BLINK_DIV3 = 3072;

    localparam int RAM_WORDS = 32;

endpackage

//--- hdl/lcdc_ram.sv
// lcdc_ram: 32 x 4 display memory with per-bit write enables.
// assumes one clock; read data comes from a register.
`timescale 1ns/1ns
module lcdc_ram
    import lcdc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [4:0] wr_addr,
    input  wire logic [3:0] wr_bits,
    input  wire logic [3:0] wr_mask,
    input  wire logic [4:0] rd_addr,
    output logic      [3:0] rd_data
);
    logic [3:0] mem [RAM_WORDS];

    always_ff @(posedge clk) begin
        for (int b = 0; b < 4; b++) begin
            if (wr_mask[b]) begin
                mem[wr_addr][b] <= wr_bits[b];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= 4'h0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

//--- hdl/lcdc_blink.sv
// lcdc_blink: blink phase generator; counts display clock ticks.
// assumes disp_tick is a one-cycle pulse per display clock period.
`timescale 1ns/1ns
module lcdc_blink
    import lcdc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       disp_tick,
    input  wire logic [1:0] rate,
    output logic            phase_reg
);
    logic [11:0] cnt_reg;
    logic [11:0] limit;
    logic        wrap;

    // toggle every limit + 1 ticks, i.e. once per full divisor [R20]
    assign limit = (rate == 2'h1) ? 12'(BLINK_DIV1 - 1) :
                   (rate == 2'h2) ? 12'(BLINK_DIV2 - 1) : 12'(BLINK_DIV3 - 1);
    assign wrap  = disp_tick && (cnt_reg >= limit);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg   <= 12'h000;
            phase_reg <= 1'b0;
        end else if (rate == 2'h0) begin
            cnt_reg   <= 12'h000;
            phase_reg <= 1'b0;
        end else if (wrap) begin
            cnt_reg   <= 12'h000;
            phase_reg <= ~phase_reg;
        end else if (disp_tick) begin
            cnt_reg   <= cnt_reg + 12'h001;
        end
    end
endmodule

//--- hdl/lcdc_decoder.sv
// lcdc_decoder: command interpreter of a segment lcd driver. takes the bytes
// that follow the slave address, decodes commands, holds status and stores
// display data.
// assumes an i2c byte layer delivering byte_valid pulses, start_frame at each
// start, and a display clock tick pulse.
//
// Operation
// R1: each post-address byte in command phase is classified by its opcode bits
// R2: bit 7 set means the next byte is also a command
// R3: bit 7 clear makes every later byte of the transfer display data
// R4: bits 6:5 = 10 is mode-set; bit 4 ignored
// R5: mode-set bit 3 blanks (0) or enables (1) the display
// R6: mode-set bit 2 picks 1/3 or 1/2 bias; ignored in static mode
// R7: mode bits 1:0: 01 static, 10 1:2, 11 1:3, 00 1:4
// R8: bits 6:5 = 00 loads the 5-bit data pointer
// R9: bits 6:3 = 1100 loads the 3-bit subaddress counter
// R10: bits 6:2 = 11110 is bank-select: input bank bit 1, output bit 0
// R11: input bank 1 stores into row 2 (static) or rows 2,3 (1:2)
// R12: output bank 1 displays row 2 (static) or rows 2,3 (1:2)
// R13: bank-select does nothing in 1:3 and 1:4 modes
// R14: bits 6:3 = 1110 is blink-select; bits 1:0 give rate
// R15: blink bit 2 picks normal or alternate-bank blinking
// R16: 1:3 and 1:4 modes always blink normally
// R17: decoded commands execute and their settings are held
// R18: data bytes fill display ram in the active mode's order
// R19: store only when subaddress matches pins; pointer advances anyway
// R20: blink rates toggle at display clock over 768, 1536, 3072
// R21: pointer overflow increments the subaddress counter
// R22: unknown command changes nothing but its continuation bit counts
`timescale 1ns/1ns
module lcdc_decoder
    import lcdc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       start_frame,
    input  wire logic       byte_valid,
    input  wire logic [7:0] byte_data,
    input  wire logic [2:0] hw_subaddr,
    input  wire logic       disp_tick,
    input  wire logic [4:0] disp_col,
    input  wire logic [1:0] disp_row,
    output lcdc_mode_t      drive_mode,
    output logic            display_enable,
    output logic            half_bias,
    output logic [4:0]      data_pointer,
    output logic [2:0]      subaddr_count,
    output logic            in_bank,
    output logic            out_bank,
    output logic [1:0]      blink_rate_field,
    output logic            alt_bank_blink_flag,
    output logic            blink_blank,
    output logic            seg_bit,
    output logic            cmd_phase,
    output logic            data_stored
);
    // ------------------------------------------------------------
    // phase state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LCDC_CMD  = 2'b01,
        LCDC_DATA = 2'b10
    } lcdc_phase_t;

    lcdc_phase_t phase_reg;
    lcdc_phase_t phase_next;
    lcdc_mode_t  mode_reg;
    logic        enable_reg, bias_reg, ibank_reg, obank_reg, altb_reg, stored_reg;
    logic [4:0]  ptr_reg;
    logic [2:0]  sub_reg;
    logic [1:0]  rate_reg;
    logic [1:0]  bit_idx_reg;
    logic        blink_phase;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire is_cmd     = byte_valid && (phase_reg == LCDC_CMD);         // [R1]
    wire is_data    = byte_valid && (phase_reg == LCDC_DATA);
    wire hit_mode   = is_cmd && byte_data[6:5] == OP_MODE_SET;       // [R4]
    wire hit_ptr    = is_cmd && byte_data[6:5] == OP_LOAD_PTR;       // [R8]
    wire hit_dev    = is_cmd && byte_data[6:3] == OP_DEV_SEL;        // [R9]
    wire hit_bank   = is_cmd && byte_data[6:2] == OP_BANK_SEL;       // [R10]
    wire hit_blink  = is_cmd && byte_data[6:3] == OP_BLINK_SEL;      // [R14]
    wire bank_mode  = (mode_reg == LCDC_STATIC) || (mode_reg == LCDC_MUX2);
    wire bank_apply = hit_bank && bank_mode;                         // [R13]

    // bits per byte: static 8 cols x1, 1:2 4x2, 1:3 3x3 (rewrite order), 1:4 2x4
    wire [1:0] rows_m1 = (mode_reg == LCDC_STATIC) ? 2'h0 :
                         (mode_reg == LCDC_MUX2)   ? 2'h1 :
                         (mode_reg == LCDC_MUX3)   ? 2'h2 : 2'h3;
    wire [2:0] cols    = (mode_reg == LCDC_STATIC) ? 3'h0 :          // 0 means 8
                         (mode_reg == LCDC_MUX2)   ? 3'h4 :
                         (mode_reg == LCDC_MUX3)   ? 3'h3 : 3'h2;

    always_comb begin
        phase_next = phase_reg;
        if (start_frame) begin
            phase_next = LCDC_CMD;
        end else if (is_cmd && !byte_data[CONT_BIT]) begin
            phase_next = LCDC_DATA;                                  // [R3] [R22]
        end
    end                                                              // [R2]

    // ------------------------------------------------------------
    // ram fill: one byte expands into column words, msb first
    // ------------------------------------------------------------
    logic [3:0] wr_bits, wr_mask;
    logic [3:0] ram_rd;
    wire  [1:0] row_base = (bank_mode && ibank_reg) ? 2'h2 : 2'h0;   // [R11]
    wire        sub_hit  = (sub_reg == hw_subaddr);                  // [R19]
    logic       fill_busy_reg;
    logic [2:0] fill_col_reg, fill_left_reg;
    logic [7:0] fill_byte_reg;
    wire  [2:0] n_cols = (cols == 3'h0) ? 3'h0 : cols;

    // in 1:3 the last column of a byte runs out of bits: its row 2 is left alone
    always_comb begin
        int src;
        src     = 0;
        wr_bits = 4'h0;
        wr_mask = 4'h0;
        for (int r = 0; r < 4; r++) begin
            src = 7 - int'(fill_col_reg) * (int'(rows_m1) + 1) - r;
            if (2'(r) <= rows_m1 && src >= 0) begin
                wr_bits[2'(r) + row_base] = fill_byte_reg[3'(src)];
                wr_mask[2'(r) + row_base] = sub_hit;
            end
        end
    end

    wire step     = fill_busy_reg;
    wire ptr_wrap = step && (ptr_reg == 5'h1f);                      // [R21]

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg     <= LCDC_CMD;
            mode_reg      <= lcdc_mode_t'(RST_MODE);
            enable_reg    <= RST_ENABLE;
            bias_reg      <= RST_BIAS;
            ptr_reg       <= RST_PTR;
            sub_reg       <= RST_SUBADR;
            ibank_reg     <= 1'b0;
            obank_reg     <= 1'b0;
            rate_reg      <= RST_BLINK;
            altb_reg      <= 1'b0;
            fill_busy_reg <= 1'b0;
            fill_col_reg  <= 3'h0;
            fill_left_reg <= 3'h0;
            fill_byte_reg <= 8'h00;
            stored_reg    <= 1'b0;
        end else begin
            phase_reg  <= phase_next;
            stored_reg <= step && sub_hit;
            if (hit_mode) begin                                      // [R17]
                enable_reg <= byte_data[ENABLE_BIT];                 // [R5]
                bias_reg   <= byte_data[BIAS_BIT];                   // [R6]
                mode_reg   <= lcdc_mode_t'(byte_data[1:0]);          // [R7]
            end
            if (bank_apply) begin
                ibank_reg <= byte_data[IBANK_BIT];
                obank_reg <= byte_data[OBANK_BIT];
            end
            if (hit_blink) begin
                rate_reg <= byte_data[1:0];
                altb_reg <= byte_data[ALTB_BIT];                     // [R15]
            end
            if (hit_ptr) begin
                ptr_reg <= byte_data[4:0];
            end else if (step) begin
                ptr_reg <= ptr_reg + 5'h01;                          // [R19]
            end
            if (hit_dev) begin
                sub_reg <= byte_data[2:0];
            end else if (ptr_wrap) begin
                sub_reg <= sub_reg + 3'h1;                           // [R21]
            end
            if (is_data && !fill_busy_reg) begin                     // [R18]
                fill_busy_reg <= 1'b1;
                fill_byte_reg <= byte_data;
                fill_col_reg  <= 3'h0;
                fill_left_reg <= n_cols - 3'h1;
            end else if (step) begin
                fill_col_reg  <= fill_col_reg + 3'h1;
                fill_left_reg <= fill_left_reg - 3'h1;
                fill_busy_reg <= (fill_left_reg != 3'h0);
            end
        end
    end

    lcdc_ram u_ram (
        .clk     (clk),
        .arst_n  (arst_n),
        .wr_addr (ptr_reg),
        .wr_bits (wr_bits),
        .wr_mask (step ? wr_mask : 4'h0),
        .rd_addr (disp_col),
        .rd_data (ram_rd)
    );

    // ------------------------------------------------------------
    // output bank and blinking
    // ------------------------------------------------------------
    lcdc_blink u_blink (
        .clk       (clk),
        .arst_n    (arst_n),
        .disp_tick (disp_tick),
        .rate      (rate_reg),
        .phase_reg (blink_phase)
    );

    // alternate-bank blinking only where a spare bank exists
    wire use_alt  = altb_reg && bank_mode;                           // [R16]
    wire show_alt = obank_reg ^ (use_alt && blink_phase);            // [R12] [R15]
    wire [1:0] rd_row = bank_mode && show_alt ? disp_row + 2'h2 : disp_row;
    logic seg_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seg_reg <= 1'b0;
        end else begin
            seg_reg <= ram_rd[rd_row];
        end
    end

    assign drive_mode          = mode_reg;
    assign display_enable      = enable_reg;
    // bias is meaningless in static drive
    assign half_bias           = (mode_reg == LCDC_STATIC) ? 1'b0 : bias_reg;  // [R6]
    assign data_pointer        = ptr_reg;
    assign subaddr_count       = sub_reg;
    assign in_bank             = ibank_reg;
    assign out_bank            = obank_reg;
    assign blink_rate_field    = rate_reg;
    assign alt_bank_blink_flag = altb_reg;
    assign blink_blank         = !use_alt && blink_phase;             // [R16]
    assign seg_bit             = seg_reg;
    assign cmd_phase           = (phase_reg == LCDC_CMD);
    assign data_stored         = stored_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_last_cmd;
        @(posedge clk) disable iff (!arst_n)
        is_cmd && !byte_data[7] && !start_frame |=> !cmd_phase;
    endproperty
    a_last_cmd: assert property (p_last_cmd) else $error("no data phase"); // [R3]

    property p_cont;
        @(posedge clk) disable iff (!arst_n)
        is_cmd && byte_data[7] |=> cmd_phase;
    endproperty
    a_cont: assert property (p_cont) else $error("left command phase"); // [R2]

    property p_mode;
        @(posedge clk) disable iff (!arst_n)
        hit_mode |=> drive_mode == $past(byte_data[1:0]) && display_enable == $past(byte_data[3]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode-set lost"); // [R7]

    property p_ptr;
        @(posedge clk) disable iff (!arst_n)
        hit_ptr |=> data_pointer == $past(byte_data[4:0]);
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer not loaded"); // [R8]

    property p_dev;
        @(posedge clk) disable iff (!arst_n)
        hit_dev |=> subaddr_count == $past(byte_data[2:0]);
    endproperty
    a_dev: assert property (p_dev) else $error("subaddress not loaded"); // [R9]

    property p_bank_ignored;
        @(posedge clk) disable iff (!arst_n)
        hit_bank && !bank_mode |=> $stable(in_bank) && $stable(out_bank);
    endproperty
    a_bank_ignored: assert property (p_bank_ignored) else $error("bank changed"); // [R13]

    property p_wrap;
        @(posedge clk) disable iff (!arst_n)
        ptr_wrap && !hit_dev |=> subaddr_count == $past(subaddr_count) + 3'h1;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no subaddress carry"); // [R21]

    property p_advance;
        @(posedge clk) disable iff (!arst_n)
        step && !hit_ptr |=> data_pointer == $past(data_pointer) + 5'h01;
    endproperty
    a_advance: assert property (p_advance) else $error("pointer stuck"); // [R19]

    property p_mux3_gap;
        @(posedge clk) disable iff (!arst_n)
        step && mode_reg == LCDC_MUX3 && fill_col_reg == 3'h2 |-> !wr_mask[2];
    endproperty
    a_mux3_gap: assert property (p_mux3_gap) else $error("1:3 spare bit written"); // [R18]

    property p_in_bank;
        @(posedge clk) disable iff (!arst_n)
        step && bank_mode && ibank_reg |-> wr_mask[1:0] == 2'b00;
    endproperty
    a_in_bank: assert property (p_in_bank) else $error("input bank ignored"); // [R11]

    c_mode:  cover property (@(posedge clk) hit_mode);
    c_data:  cover property (@(posedge clk) step && sub_hit);
    c_blink: cover property (@(posedge clk) hit_blink ##1 !cmd_phase);
    c_alt:   cover property (@(posedge clk) use_alt && blink_phase);
endmodule

//--- testbench/lcdc_master_model.sv
// lcdc_master_model: byte level stand-in for the bus master that feeds the decoder.
// assumes one caller at a time; all lines change at the falling clock edge.
`timescale 1ns/1ns
module lcdc_master_model (
    input  wire logic       clk,
    output logic            start_frame,
    output logic            byte_valid,
    output logic      [7:0] byte_data
);
    initial begin
        start_frame = 1'b0;
        byte_valid  = 1'b0;
        byte_data   = 8'h00;
    end

    // ------------------------------------------------------------
    // one transfer unit, optionally behind a start condition
    // ------------------------------------------------------------
    // the caller sets bit 7 of each command byte as the continuation flag
    task automatic send(input logic st, input logic [7:0] b);
        if (st) begin
            @(negedge clk);
            start_frame = 1'b1;
            @(negedge clk);
            start_frame = 1'b0;
        end
        @(negedge clk);
        byte_valid = 1'b1;
        byte_data  = b;
        @(negedge clk);
        byte_valid = 1'b0;
        // released lane shows the inverse so a stale copy cannot pass
        byte_data  = ~b;
        // leaves room for the slowest column walk (8 columns in static)
        repeat (11) @(negedge clk);
    endtask
endmodule

//--- testbench/lcdc_decoder_tb.sv
// lcdc_decoder_tb: self-checking bench for the lcd command decoder.
// assumes lcdc_pkg and the master model are compiled first.
`timescale 1ns/1ns
module lcdc_decoder_tb;
    import lcdc_pkg::*;
    typedef struct { logic [17:0] st; int stored; } lcdc_note_t;
    logic clk = 1'b0, arst_n = 1'b0, start_frame, byte_valid, disp_tick = 1'b0;
    logic [7:0] byte_data;
    logic [2:0] hw_subaddr = 3'h0;
    logic [4:0] disp_col = 5'h00;
    logic [1:0] disp_row = 2'h0;
    lcdc_mode_t drive_mode;
    logic display_enable, half_bias, in_bank, out_bank, alt_bank_blink_flag;
    logic blink_blank, seg_bit, cmd_phase, data_stored;
    logic [4:0] data_pointer;
    logic [2:0] subaddr_count;
    logic [1:0] blink_rate_field;
    logic [1:0] e_mode = 2'h0, e_br = 2'h0;
    logic e_en = 1'b0, e_bias = 1'b0, e_ib = 1'b0, e_ob = 1'b0, e_ab = 1'b0, e_cmd = 1'b1;
    logic [4:0] e_ptr = 5'h00;
    logic [2:0] e_sub = 3'h0;
    logic [31:0] rng = 32'hea09;
    int e_stored = 0, seen_stored = 0, miscompares = 0, checks_done = 0;
    lcdc_note_t q[$];

    always #2 clk = ~clk;

    lcdc_master_model i_mst (.clk(clk), .start_frame(start_frame), .byte_valid(byte_valid),
        .byte_data(byte_data));
    lcdc_decoder i_dut (.clk(clk), .arst_n(arst_n), .start_frame(start_frame),
        .byte_valid(byte_valid), .byte_data(byte_data), .hw_subaddr(hw_subaddr),
        .disp_tick(disp_tick), .disp_col(disp_col), .disp_row(disp_row),
        .drive_mode(drive_mode), .display_enable(display_enable), .half_bias(half_bias),
        .data_pointer(data_pointer), .subaddr_count(subaddr_count), .in_bank(in_bank),
        .out_bank(out_bank), .blink_rate_field(blink_rate_field),
        .alt_bank_blink_flag(alt_bank_blink_flag), .blink_blank(blink_blank),
        .seg_bit(seg_bit), .cmd_phase(cmd_phase), .data_stored(data_stored));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // expected state advances here, then the note is queued and the byte sent
    task automatic xfer(input logic st, input logic [7:0] b);
        int n;
        if (st) e_cmd = 1'b1;
        if (!e_cmd) begin
            n = (e_mode == 2'h1) ? 8 : (e_mode == 2'h2) ? 4 : (e_mode == 2'h3) ? 3 : 2;
            repeat (n) begin
                if (e_sub == hw_subaddr) e_stored++;
                e_ptr = e_ptr + 5'h01;
                if (e_ptr == 5'h00) e_sub = e_sub + 3'h1;
            end
        end else begin
            e_cmd = b[CONT_BIT];
            if (b[6:5] == OP_MODE_SET) begin
                e_en   = b[ENABLE_BIT];
                e_mode = b[1:0];
                e_bias = b[BIAS_BIT] & (b[1:0] != 2'h1);
            end else if (b[6:5] == OP_LOAD_PTR) e_ptr = b[4:0];
            else if (b[6:3] == OP_DEV_SEL) e_sub = b[2:0];
            else if (b[6:2] == OP_BANK_SEL && e_mode inside {2'h1, 2'h2}) {e_ib, e_ob} = b[1:0];
            else if (b[6:3] == OP_BLINK_SEL) {e_ab, e_br} = b[2:0];
        end
        q.push_back('{st: {e_mode, e_en, e_bias, e_ptr, e_sub, e_ib, e_ob, e_br, e_ab, e_cmd},
            stored: e_stored});
        i_mst.send(st, b);
    endtask

    task automatic seg_read(input logic [7:0] exp);
        for (int c = 0; c < 8; c++) begin
            disp_col = c[4:0];
            repeat (3) @(negedge clk);
            check(seg_bit, exp[7-c], "segment bit");
        end
    endtask

    // measures the gap between two blank toggles; lim means none seen
    task automatic blink_gap(input int per, input int lim);
        int k;
        logic b0;
        for (int p = 0; p < 2; p++) begin
            b0 = blink_blank;
            k = 0;
            while (blink_blank === b0 && k < lim) begin
                @(negedge clk);
                k++;
            end
        end
        check(k, per, "blink gap");
    endtask

    // ------------------------------------------------------------
    // result watcher
    // ------------------------------------------------------------
    always @(negedge clk) if (data_stored === 1'b1) seen_stored++;

    initial begin
        lcdc_note_t n;
        forever begin
            @(posedge clk iff byte_valid === 1'b1);
            repeat (10) @(negedge clk);
            n = q.pop_front();
            check({drive_mode, display_enable, half_bias, data_pointer, subaddr_count, in_bank,
                out_bank, blink_rate_field, alt_bank_blink_flag, cmd_phase}, n.st, "state");
            check(seen_stored, n.stored, "stored columns");
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        check({drive_mode, display_enable, half_bias, data_pointer, cmd_phase}, 10'h001, "reset");
        for (int m = 0; m < 4; m++) begin
            xfer(1'b1, 8'hdc | m[7:0]);
            xfer(1'b0, 8'hc0 | m[7:0]);
        end
        $display("test modes done");
        xfer(1'b1, 8'he8);
        xfer(1'b0, 8'h85);
        xfer(1'b0, 8'hfb);
        $display("test unknown and ignored bank done");
        xfer(1'b1, 8'hc9);
        xfer(1'b0, 8'hf8);
        xfer(1'b0, 8'he0);
        xfer(1'b0, 8'hf0);
        xfer(1'b0, 8'h00);
        xfer(1'b0, 8'ha5);
        xfer(1'b1, 8'hfa);
        xfer(1'b0, 8'h00);
        xfer(1'b0, 8'h3c);
        seg_read(8'ha5);
        xfer(1'b1, 8'h79);
        seg_read(8'h3c);
        $display("test banks done");
        xfer(1'b1, 8'he5);
        xfer(1'b0, 8'h00);
        rng = xs(rng);
        xfer(1'b0, rng[7:0]);
        xfer(1'b1, 8'hc8);
        xfer(1'b0, 8'he0);
        xfer(1'b0, 8'h1f);
        rng = xs(rng);
        xfer(1'b0, rng[7:0]);
        hw_subaddr = 3'h1;
        for (int m = 2; m < 4; m++) begin
            xfer(1'b1, 8'hc8 | m[7:0]);
            rng = xs(rng);
            xfer(1'b0, {3'b000, rng[4:0]});
            repeat (3) begin
                rng = xs(rng);
                xfer(1'b0, rng[7:0]);
            end
        end
        $display("test data walk done");
        disp_tick = 1'b1;
        xfer(1'b1, 8'hc8);
        xfer(1'b0, 8'h71);
        blink_gap(BLINK_DIV1, 4000);
        xfer(1'b1, 8'h72);
        blink_gap(BLINK_DIV2, 4000);
        xfer(1'b1, 8'h73);
        blink_gap(BLINK_DIV3, 4000);
        xfer(1'b1, 8'h75);
        blink_gap(BLINK_DIV1, 4000);
        xfer(1'b1, 8'hc9);
        xfer(1'b0, 8'h75);
        blink_gap(2000, 2000);
        xfer(1'b1, 8'h70);
        blink_gap(2000, 2000);
        $display("test blink done");
        report_and_stop();
    end
endmodule
